// *** csf_ctrl.v ***
// status, event flags, acceptance filter, receive buffers and prescaler
// of a can controller. assumes a protocol engine that reports frame
// progress as pulses and a cpu on the byte-wide register port.
`timescale 1ns/10ps
`include "csf_regs.vh"
module csf_ctrl #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [4:0]  cpu_addr,
  input  wire [7:0]  cpu_wdata,
  input  wire        cpu_wr,
  input  wire        cpu_rd,
  output reg  [7:0]  cpu_rdata,
  output reg         can_irq_line,
  input  wire        rx_start,
  input  wire        rx_id_valid,
  input  wire [10:0] rx_id,
  input  wire        rx_byte_valid,
  output wire        rx_byte_ready,
  input  wire        rx_byte_first,
  input  wire [7:0]  rx_byte,
  input  wire        rx_ok,
  input  wire        rx_err,
  input  wire        rx_own,
  input  wire        tx_start,
  input  wire        tx_ok,
  input  wire        tx_fail,
  input  wire [3:0]  tx_buf_addr,
  output reg  [7:0]  tx_buf_data,
  output reg         tx_pending,
  input  wire        err_warn_in,
  input  wire        bus_off_in,
  input  wire        bus_free,
  input  wire        bus_activity,
  output reg         err_cnt_reset,
  output reg         proto_hold,
  output reg         tq_tick,
  input  wire        resync_req,
  input  wire [3:0]  resync_phase,
  output reg  [3:0]  resync_jump
);
  reg  [7:0] ctrl;
  reg  [7:0] filter_match;
  reg  [7:0] filter_mask;
  reg  [7:0] bit_timing_prescale;
  reg  [7:0] event_flags;
  reg        rx_buffer_full;
  reg        overrun;
  reg        tx_buffer_free;
  reg        tx_done_flag;
  reg        rx_active;
  reg        tx_active;
  reg        error_warn_flag;
  reg        bus_off_flag;
  reg        sleep_req;
  reg        sleeping;
  reg        wake_mode;
  reg  [1:0] rx_sel;
  reg  [1:0] buf_count;
  reg        cpu_buf;
  reg        rx_keep;
  reg        commit_pend;
  reg        commit_own;
  reg  [3:0] wr_idx;
  reg  [7:0] free_count;
  reg  [6:0] tq_count;
  reg  [7:0] tx_mem [0:9];
  reg  [7:0] rx_mem [0:19];
  reg  [7:0] rd_val;
  reg  [7:0] ev_set;

  wire       hold_in_init = ctrl[`CSF_C_HOLD];
  wire       rx_irq_en = ctrl[`CSF_C_RXIE];
  wire       tx_irq_en = ctrl[`CSF_C_TXIE];
  wire       err_irq_en = ctrl[`CSF_C_ERRIE];
  wire       overrun_irq_en = ctrl[`CSF_C_OVRIE];
  wire [5:0] bit_clock_divider = bit_timing_prescale[`CSF_BRP_HI:0];
  wire [1:0] resync_jump_limit = bit_timing_prescale[7:`CSF_SJW_LO];
  wire [7:0] filter_match_bits = filter_match;
  wire [7:0] filter_dontcare_bits = filter_mask;
  wire [7:0] ctrl_state_reg = {bus_off_flag, error_warn_flag, tx_active,
                               rx_active, tx_done_flag, tx_buffer_free,
                               overrun, rx_buffer_full};

  // cpu strobes per register
  wire wr_ctrl = cpu_wr & (cpu_addr == `CSF_A_CTRL);
  wire wr_cmd  = cpu_wr & (cpu_addr == `CSF_A_CMD);
  wire rd_evt  = cpu_rd & (cpu_addr == `CSF_A_EVT);
  wire cmd_tr  = wr_cmd & cpu_wdata[`CSF_K_TXREQ];
  wire cmd_at  = wr_cmd & cpu_wdata[`CSF_K_ABORT];
  wire cmd_rel = wr_cmd & cpu_wdata[`CSF_K_RELEASE];
  wire cmd_cos = wr_cmd & cpu_wdata[`CSF_K_CLROVR];
  wire in_txbuf = (cpu_addr >= `CSF_A_TXBUF) & (cpu_addr < `CSF_A_RXBUF);
  wire in_rxbuf = (cpu_addr >= `CSF_A_RXBUF) &
                  (cpu_addr < `CSF_A_RXBUF + `CSF_MSG_BYTES);
  wire [4:0] tx_off = cpu_addr - `CSF_A_TXBUF;
  wire [4:0] rx_off = cpu_addr - `CSF_A_RXBUF;

  // buffer address inside the two-message receive store
  function [4:0] buf_addr;
    input       sel;
    input [3:0] idx;
    begin
      buf_addr = {1'b0, idx} + (sel ? `CSF_MSG_BYTES : 5'h00);
    end
  endfunction

  // jump clipped to limit, both in quanta
  function [3:0] clip;
    input [3:0] want;
    input [3:0] lim;
    begin
      clip = (want > lim) ? lim : want;
    end
  endfunction

  // identifier top bits against code where the mask bit is low; set mask bits are don't-care
  wire accept = ((rx_id[10:3] ^ filter_match_bits) &
                 ~filter_dontcare_bits) == 8'h00; // RQ19

  // overrun or free buffer decided when the identifier is valid
  wire id_hit = rx_id_valid & accept & ~hold_in_init;
  wire ovr_set = id_hit & (buf_count == 2'd2); // RQ2 RQ4
  wire store_go = id_hit & (buf_count != 2'd2);

  // receive bytes pass a fifo; bytes of a dropped message never enter
  wire       f_out_valid;
  wire [8:0] f_out_data;
  wire       cpu_rx_read = cpu_rd & in_rxbuf;
  wire       f_out_ready = ~cpu_rx_read; // rx store has one port
  wire       drain = f_out_valid & f_out_ready;
  wire [3:0] wr_pos = f_out_data[8] ? 4'h0 : wr_idx;
  wire       wr_buf = cpu_buf ^ (buf_count != 2'd0);
  wire       commit = commit_pend & ~f_out_valid & ~hold_in_init;

  csf_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (rx_byte_valid & rx_keep),
    .in_ready  (rx_byte_ready),
    .in_data   ({rx_byte_first, rx_byte}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // stored bytes go to the cpu buffer when no message is held, else to the other one, in order
  always @(posedge clk_sys)
  begin
    if (drain & (wr_pos < `CSF_MSG_BYTES))
      rx_mem[buf_addr(wr_buf, wr_pos)] <= f_out_data[7:0]; // RQ18
    if (cpu_wr & in_txbuf & tx_buffer_free & ~hold_in_init)
      tx_mem[tx_off[3:0]] <= cpu_wdata; // RQ5
  end

  // error event on any edge of warning or bus-off; others from causes
  wire next_tbs_rise;
  reg  tbs_prev;
  reg  es_prev;
  reg  bs_prev;
  assign next_tbs_rise = tx_buffer_free & ~tbs_prev;
  always @*
  begin
    ev_set = 8'h00;
    ev_set[`CSF_E_RX] = commit & ~commit_own & rx_irq_en; // RQ12 RQ4
    ev_set[`CSF_E_TX] = next_tbs_rise & tx_irq_en; // RQ13
    ev_set[`CSF_E_ERR] = ((error_warn_flag ^ es_prev) |
                          (bus_off_flag ^ bs_prev)) & err_irq_en; // RQ14
    ev_set[`CSF_E_OVR] = ovr_set & overrun_irq_en; // RQ15
    ev_set[`CSF_E_WAKE] = sleeping & (~sleep_req | bus_activity); // RQ16
  end

  // register read mux; closed registers and holes read as ones
  always @*
  begin
    rd_val = `CSF_READ_IDLE;
    case (cpu_addr)
      `CSF_A_CTRL:  rd_val = ctrl | 8'h80;
      `CSF_A_CMD:   rd_val = {ctrl_cmd_hi(rx_sel, wake_mode, sleeping), 4'hf};
      `CSF_A_STAT:  rd_val = ctrl_state_reg;
      `CSF_A_EVT:   rd_val = event_flags;
      `CSF_A_MATCH: if (hold_in_init) rd_val = filter_match; // RQ17
      `CSF_A_MASK:  if (hold_in_init) rd_val = filter_mask; // RQ17
      `CSF_A_BTIME: if (hold_in_init) rd_val = bit_timing_prescale;
      default:
      begin
        if (in_txbuf)
          rd_val = tx_mem[tx_off[3:0]];
        else if (in_rxbuf)
          rd_val = rx_mem[buf_addr(cpu_buf, rx_off[3:0])];
      end
    endcase
  end

  // upper command bits read back the switch and sleep state
  function [3:0] ctrl_cmd_hi;
    input [1:0] sel;
    input       wm;
    input       slp;
    begin
      ctrl_cmd_hi = {sel[0], sel[1], wm, slp};
    end
  endfunction

  // cpu port, config registers and event flags
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_rdata           <= 8'h00;
      ctrl                <= `CSF_CTRL_RST;
      filter_match        <= 8'h00;
      filter_mask         <= 8'h00;
      bit_timing_prescale <= 8'h00;
      event_flags         <= 8'h00;
      can_irq_line        <= 1'b0;
      rx_sel              <= 2'b11;
      wake_mode           <= 1'b0;
      tbs_prev            <= 1'b1;
      es_prev             <= 1'b0;
      bs_prev             <= 1'b0;
    end
    else
    begin
      if (cpu_rd)
        cpu_rdata <= rd_val;
      tbs_prev <= tx_buffer_free;
      es_prev  <= error_warn_flag;
      bs_prev  <= bus_off_flag;
      // set wins over the read clear so no event is lost
      event_flags <= ((rd_evt ? 8'h00 : event_flags) | ev_set) &
                     (hold_in_init ? 8'h14 : 8'h1f); // RQ11 RQ24 RQ16
      can_irq_line <= |ev_set |
                      (~rd_evt & |(event_flags &
                       (hold_in_init ? 8'h14 : 8'h1f))); // RQ11
      if (wr_cmd)
      begin
        wake_mode <= cpu_wdata[`CSF_K_WAKEMODE];
        rx_sel    <= {cpu_wdata[`CSF_K_RX0A], cpu_wdata[`CSF_K_RX1A]};
      end
      // bus-off entry forces hold regardless of a cpu write
      if (bus_off_in & ~bus_off_flag)
        ctrl[`CSF_C_HOLD] <= 1'b1; // RQ10
      else if (wr_ctrl)
        ctrl[`CSF_C_HOLD] <= cpu_wdata[`CSF_C_HOLD];
      if (wr_ctrl)
      begin
        ctrl[`CSF_C_OVRIE:`CSF_C_RXIE] <= cpu_wdata[4:1];
        if (hold_in_init)
          ctrl[`CSF_C_SYNC2:`CSF_C_REFOUT] <= cpu_wdata[6:5];
      end
      if (cpu_wr & hold_in_init)
      begin
        if (cpu_addr == `CSF_A_MATCH)
          filter_match <= cpu_wdata; // RQ17
        if (cpu_addr == `CSF_A_MASK)
          filter_mask <= cpu_wdata; // RQ17
        if (cpu_addr == `CSF_A_BTIME)
          bit_timing_prescale <= cpu_wdata; // RQ17
      end
    end
  end

  // transmit side: request, abort, completion, activity
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_buffer_free <= 1'b1;
      tx_done_flag   <= 1'b1;
      tx_pending     <= 1'b0;
      tx_active      <= 1'b0;
      tx_buf_data    <= 8'h00;
    end
    else
    begin
      tx_buf_data <= (tx_buf_addr < `CSF_MSG_BYTES) ?
                     tx_mem[tx_buf_addr] : 8'h00;
      if (hold_in_init)
      begin
        tx_buffer_free <= 1'b1; // RQ22
        tx_done_flag   <= 1'b1;
        tx_pending     <= 1'b0;
        tx_active      <= 1'b0;
      end
      else if (tx_ok)
      begin
        tx_buffer_free <= 1'b1;
        tx_done_flag   <= 1'b1; // RQ6
        tx_pending     <= 1'b0;
        tx_active      <= 1'b0; // RQ8
      end
      else
      begin
        if (cmd_at & tx_pending & ~tx_active & ~tx_start)
        begin
          tx_buffer_free <= 1'b1; // RQ7
          tx_pending     <= 1'b0;
        end
        else if (cmd_tr & tx_buffer_free)
        begin
          tx_buffer_free <= 1'b0; // RQ5
          tx_done_flag   <= 1'b0; // RQ6
          tx_pending     <= 1'b1;
        end
        if (tx_start & tx_pending)
          tx_active <= 1'b1; // RQ8
        else if (tx_fail)
          tx_active <= 1'b0;
      end
    end
  end

  // receive side: filter, overrun, buffer queue and flags
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_active      <= 1'b0;
      rx_keep        <= 1'b0;
      commit_pend    <= 1'b0;
      commit_own     <= 1'b0;
      buf_count      <= 2'd0;
      cpu_buf        <= 1'b0;
      rx_buffer_full <= 1'b0;
      overrun        <= 1'b0;
      wr_idx         <= 4'h0;
    end
    else if (hold_in_init)
    begin
      rx_active      <= 1'b0; // RQ22
      rx_keep        <= 1'b0;
      commit_pend    <= 1'b0;
      buf_count      <= 2'd0;
      rx_buffer_full <= 1'b0;
      overrun        <= 1'b0;
    end
    else
    begin
      if (drain)
        wr_idx <= wr_pos + 4'h1;
      if (rx_start)
        rx_active <= 1'b1; // RQ8
      else if (rx_ok | rx_err)
        rx_active <= 1'b0;
      // a dropped message never reaches the buffer; no overload frame
      if (store_go)
        rx_keep <= 1'b1;
      else if (ovr_set | rx_ok | rx_err)
        rx_keep <= 1'b0; // RQ3
      if (rx_ok & rx_keep)
      begin
        commit_pend <= 1'b1; // RQ18
        commit_own  <= rx_own;
      end
      else if (commit)
        commit_pend <= 1'b0;
      if (ovr_set)
        overrun <= 1'b1; // RQ2
      else if (cmd_cos)
        overrun <= 1'b0;
      if (cmd_rel & (buf_count != 2'd0))
        cpu_buf <= ~cpu_buf;
      buf_count <= buf_count + {1'b0, commit} -
                   {1'b0, cmd_rel & (buf_count != 2'd0)};
      // new store beats a release in the same cycle
      if (commit & ~commit_own)
        rx_buffer_full <= 1'b1; // RQ1 RQ4
      else if (cmd_rel)
        rx_buffer_full <= 1'b0; // RQ1 RQ23
    end
  end

  // error state, bus-off recovery and sleep
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      error_warn_flag <= 1'b0;
      bus_off_flag    <= 1'b0;
      free_count      <= 8'h00;
      err_cnt_reset   <= 1'b0;
      sleep_req       <= 1'b0;
      sleeping        <= 1'b0;
      proto_hold      <= 1'b1;
    end
    else
    begin
      proto_hold    <= hold_in_init; // RQ22
      err_cnt_reset <= 1'b0;
      if (bus_off_in)
        bus_off_flag <= 1'b1; // RQ10
      // counters clear only after the full wait of free periods
      if (bus_off_flag & ~hold_in_init & bus_free)
      begin
        if (free_count == `CSF_BUSOFF_FREE - 8'd1)
        begin
          free_count      <= 8'h00;
          bus_off_flag    <= 1'b0; // RQ10
          err_cnt_reset   <= 1'b1;
        end
        else
          free_count <= free_count + 8'd1;
      end
      else if (hold_in_init)
        free_count <= 8'h00;
      if (err_cnt_reset)
        error_warn_flag <= 1'b0;
      else
        error_warn_flag <= err_warn_in; // RQ9
      // bus activity wakes and cancels the sleep request
      if (hold_in_init | (sleeping & bus_activity))
        sleep_req <= 1'b0;
      else if (wr_cmd)
        sleep_req <= cpu_wdata[`CSF_K_SLEEP];
      if (sleeping)
        sleeping <= sleep_req & ~bus_activity; // RQ16
      else
        sleeping <= sleep_req & ~can_irq_line & ~rx_active &
                    ~tx_active & ~hold_in_init;
    end
  end

  // time quantum every 2*(prescale+1) clocks; restarts in hold
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tq_count    <= 7'h00;
      tq_tick     <= 1'b0;
      resync_jump <= 4'h0;
    end
    else
    begin
      tq_tick <= 1'b0;
      if (hold_in_init)
        tq_count <= 7'h00;
      else if (tq_count >= {bit_clock_divider, 1'b1})
      begin
        tq_count <= 7'h00;
        tq_tick  <= 1'b1; // RQ20
      end
      else
        tq_count <= tq_count + 7'h01;
      if (resync_req & ~hold_in_init)
        resync_jump <= clip(resync_phase,
                            {2'b00, resync_jump_limit} + 4'h1); // RQ21
      else
        resync_jump <= 4'h0;
    end
  end
endmodule

// *** csf_ctrl_chk.sv ***
// port checker of the can status and filter block.
// assumes a bind onto csf_ctrl; sees its ports only.
`timescale 1ns/10ps
module csf_ctrl_chk (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire [4:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire       cpu_wr,
  input wire       cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire       tx_ok,
  input wire       tx_pending,
  input wire       bus_off_in,
  input wire       err_cnt_reset,
  input wire       proto_hold,
  input wire       tq_tick,
  input wire       resync_req,
  input wire [3:0] resync_jump
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a quantum never lasts under two clocks
  chk_tq_gap: assert property (tq_tick |=> !tq_tick)
    else $error("tq pulse too long");
  // jump only answers a request, never beyond four quanta
  chk_jump_idle: assert property (!resync_req |=> resync_jump == 4'h0)
    else $error("jump without request");
  chk_jump_lim: assert property (resync_req |=> resync_jump <= 4'h4)
    else $error("jump above limit");
  chk_busoff_hold: assert property (bus_off_in |-> ##2 proto_hold [*3])
    else $error("hold not forced");
  // only the cpu may drop hold
  chk_hold_fall: assert property ($fell(proto_hold) |->
    $past(cpu_wr && cpu_addr == 5'h00 && !cpu_wdata[0], 2))
    else $error("hold fell by itself");
  chk_err_pulse: assert property (err_cnt_reset |=> !err_cnt_reset)
    else $error("counter reset too long");
  chk_ok_frees: assert property (tx_ok |=> !tx_pending)
    else $error("pending after success");
  chk_rdata_holds: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved");
  cover property (tx_ok);
  cover property (err_cnt_reset);
  cover property (resync_req ##1 resync_jump != 4'h0);
endmodule

// *** csf_fifo.v ***
// parameterised first-in first-out buffer with valid/ready on both sides.
// assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module csf_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;
  wire [AW:0]     next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rd_ptr];

  // storage has no reset; only pointers, fill count and flags need one
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // full and empty kept as flops so both ready and valid are clean
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      fill      <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      fill      <= next_fill;
      in_ready  <= (next_fill != DEPTH);
      out_valid <= (next_fill != {(AW+1){1'b0}});
    end
  end
endmodule

// *** csf_peer.sv ***
// frame source standing in for the other nodes on the bus.
// assumes the caller drives send from the clock domain of clk_sys.
`timescale 1ns/10ps
module csf_peer (
  input  wire        clk_sys,
  output reg         rx_start,
  output reg         rx_id_valid,
  output reg  [10:0] rx_id,
  output reg         rx_byte_valid,
  input  wire        rx_byte_ready,
  output reg         rx_byte_first,
  output reg  [7:0]  rx_byte,
  output reg         rx_ok,
  output reg         rx_own
);
  integer i;
  reg     rdy_s;
  // ready taken mid-cycle so the edge test never races the flop
  always @(negedge clk_sys)
    rdy_s <= rx_byte_ready;
  initial
  begin
    {rx_start, rx_id_valid, rx_byte_valid, rx_ok, rx_own} = 5'h00;
    rx_id = 11'h000;
    rx_byte_first = 1'b0;
    rx_byte = 8'h00;
  end
  // descriptor pair then one data byte, in order
  task send(input [10:0] id, input own);
    begin
      @(posedge clk_sys);
      rx_start <= 1'b1;
      rx_own <= own;
      @(posedge clk_sys);
      rx_start <= 1'b0;
      rx_id_valid <= 1'b1;
      rx_id <= id;
      @(posedge clk_sys);
      rx_id_valid <= 1'b0;
      rx_id <= ~id;
      @(posedge clk_sys);
      for (i = 0; i < 3; i = i + 1)
      begin
        rx_byte_valid <= 1'b1;
        rx_byte_first <= (i == 0);
        rx_byte <= i == 0 ? id[10:3] : i == 1 ? {id[2:0], 5'h01} : 8'ha5;
        do @(posedge clk_sys); while (!rdy_s);
      end
      // released byte lines show the inverse, not a stale value
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      rx_ok <= 1'b1;
      @(posedge clk_sys);
      rx_ok <= 1'b0;
      rx_own <= 1'b0;
    end
  endtask
endmodule

// *** csf_regs.vh ***
// register addresses, bit positions, reset values and counts of the
// can status, event, filter and prescaler block; no logic here.
// Operation
// (RQ1) Receive-full flag sets on a new message, clears on release, sets on next store.
// (RQ2) Overrun sets when both buffers full and another message must store; cleared by command.
// (RQ3) On overrun the incoming message is dropped and no overload frame is sent.
// (RQ4) Own accepted transmission is stored or overruns, but no receive flag or event.
// (RQ5) Transmit-buffer-free low while a message waits or sends; writes then silently dropped.
// (RQ6) Transmit-done clears on transmit request and sets only on its successful finish.
// (RQ7) Abort releases the transmit buffer; unsent aborted message leaves transmit-done low.
// (RQ8) Receive-active and transmit-active report activity; both low means bus idle.
// (RQ9) Error-warning flag follows whether either error counter reached the warning limit.
// (RQ10) Bus-off forces hold-in-init; after release wait 128 bus-free, then clear and reset counters.
// (RQ11) Interrupt line high while any event bit set; reading event register clears all.
// (RQ12) Receive event sets with the receive-full flag when enabled.
// (RQ13) Transmit event sets on transmit-buffer-free rising when enabled.
// (RQ14) Error event sets on any change of error-warning or bus-off when enabled.
// (RQ15) Overrun event sets together with the overrun flag when enabled.
// (RQ16) Wake event sets on leaving sleep; event bits 5 to 7 reserved.
// (RQ17) Filter and prescale registers readable and writable only while hold-in-init high.
// (RQ18) Accepted message bytes stored in order; flags only after correct complete reception.
// (RQ19) Accept when identifier bits 10..3 match code where mask bit low.
// (RQ20) Time quantum is two clocks times prescale value plus one.
// (RQ21) Resynchronisation jump limited to jump-width field plus one quanta.
// (RQ22) Hold-in-init aborts transfers and holds reset state until it falls.
// (RQ23) CPU must release the receive buffer after reading it.
// (RQ24) An event arriving during the event register read stays set.
`ifndef CSF_REGS_VH
`define CSF_REGS_VH
// register addresses on the byte port
`define CSF_A_CTRL      5'h00
`define CSF_A_CMD       5'h01
`define CSF_A_STAT      5'h02
`define CSF_A_EVT       5'h03
`define CSF_A_MATCH     5'h04
`define CSF_A_MASK      5'h05
`define CSF_A_BTIME     5'h06
`define CSF_A_TXBUF     5'h0a
`define CSF_A_RXBUF     5'h14
`define CSF_MSG_BYTES   5'h0a
// control bits
`define CSF_C_HOLD      0
`define CSF_C_RXIE      1
`define CSF_C_TXIE      2
`define CSF_C_ERRIE     3
`define CSF_C_OVRIE     4
`define CSF_C_REFOUT    5
`define CSF_C_SYNC2     6
`define CSF_CTRL_RST    8'ha1
// command bits
`define CSF_K_TXREQ     0
`define CSF_K_ABORT     1
`define CSF_K_RELEASE   2
`define CSF_K_CLROVR    3
`define CSF_K_SLEEP     4
`define CSF_K_WAKEMODE  5
`define CSF_K_RX1A      6
`define CSF_K_RX0A      7
// event bits
`define CSF_E_RX        0
`define CSF_E_TX        1
`define CSF_E_ERR       2
`define CSF_E_OVR       3
`define CSF_E_WAKE      4
// bit timing fields
`define CSF_BRP_HI      5
`define CSF_SJW_LO      6
`define CSF_READ_IDLE   8'hff
`define CSF_BUSOFF_FREE 8'd128
`endif

// *** testbench.sv ***
// self-checking bench of the can status and filter block.
// assumes csf_ctrl fed by csf_peer, cpu port driven here.
`timescale 1ns/10ps
module testbench;
  reg        clk_sys, sys_rst, cpu_wr, cpu_rd, tx_start, tx_ok;
  reg        bus_off_in, bus_free, resync_req, seen, ew;
  reg  [4:0] cpu_addr;
  reg  [7:0] cpu_wdata;
  reg  [3:0] resync_phase;
  wire [7:0] cpu_rdata, tx_buf_data;
  wire [10:0] rid;
  wire [7:0] rb;
  wire [3:0] resync_jump;
  wire       irq, rs, iv, bv, br, bf, ok, own, pend, ecr, hold, tq;
  integer    error_cnt = 0;
  integer    num_checks = 0;
  integer    n;
  csf_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .can_irq_line(irq),
    .rx_start(rs), .rx_id_valid(iv), .rx_id(rid), .rx_byte_valid(bv),
    .rx_byte_ready(br), .rx_byte_first(bf), .rx_byte(rb), .rx_ok(ok),
    .rx_err(1'b0), .rx_own(own), .tx_start(tx_start), .tx_ok(tx_ok),
    .tx_fail(1'b0), .tx_buf_addr(4'h0), .tx_buf_data(tx_buf_data),
    .tx_pending(pend), .err_warn_in(ew), .bus_off_in(bus_off_in),
    .bus_free(bus_free), .bus_activity(1'b0), .err_cnt_reset(ecr),
    .proto_hold(hold), .tq_tick(tq), .resync_req(resync_req),
    .resync_phase(resync_phase), .resync_jump(resync_jump));
  csf_peer p (.clk_sys(clk_sys), .rx_start(rs), .rx_id_valid(iv),
    .rx_id(rid), .rx_byte_valid(bv), .rx_byte_ready(br),
    .rx_byte_first(bf), .rx_byte(rb), .rx_ok(ok), .rx_own(own));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // counter reset is a one-cycle pulse, so latch it
  always @(posedge clk_sys)
    if (ecr)
      seen <= 1'b1;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      cpu_wr <= 1'b1;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge clk_sys);
      cpu_wr <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys);
      cpu_rd <= 1'b1;
      cpu_addr <= a;
      @(posedge clk_sys);
      cpu_rd <= 1'b0;
      #1 chk(cpu_rdata, exp);
    end
  endtask
  task t_regs;
    begin
      rd(5'h00, 8'ha1);
      rd(5'h02, 8'h0c);
      wr(5'h04, 8'h5a);
      wr(5'h05, 8'h0f);
      wr(5'h06, 8'h41);
      rd(5'h05, 8'h0f);
      rd(5'h1f, 8'hff);
      wr(5'h00, 8'h1e);
      rd(5'h04, 8'hff);
      wr(5'h04, 8'h00);
    end
  endtask
  task t_timing;
    begin
      @(posedge tq);
      n = 0;
      do begin @(posedge clk_sys); #1 n = n + 1; end while (!tq && n < 99);
      chk(n[7:0], 8'h04);
      @(posedge clk_sys);
      resync_phase <= 4'hf;
      resync_req <= 1'b1;
      @(posedge clk_sys);
      resync_req <= 1'b0;
      #1 chk({4'h0, resync_jump}, 8'h02);
    end
  endtask
  task t_rx;
    begin
      p.send(11'h29f, 1'b0);
      n = 0;
      while (!irq && n < 40) begin @(posedge clk_sys); n = n + 1; end
      rd(5'h02, 8'h0d);
      rd(5'h03, 8'h01);
      rd(5'h03, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wr(5'h01, 8'h04);
      p.send(11'h31f, 1'b0);
      repeat (20) @(posedge clk_sys);
      rd(5'h02, 8'h0c);
      repeat (3) p.send(11'h2a7, 1'b0);
      repeat (20) @(posedge clk_sys);
      rd(5'h02, 8'h0f);
      rd(5'h03, 8'h09);
      wr(5'h01, 8'h0c);
      rd(5'h02, 8'h0c);
      p.send(11'h29f, 1'b1);
      repeat (20) @(posedge clk_sys);
      rd(5'h02, 8'h0c);
      rd(5'h03, 8'h00);
    end
  endtask
  task t_tx;
    begin
      wr(5'h0a, 8'h3c);
      wr(5'h01, 8'h01);
      rd(5'h02, 8'h00);
      wr(5'h0a, 8'h77);
      @(posedge clk_sys);
      #1 chk(tx_buf_data, 8'h3c);
      @(posedge clk_sys);
      tx_start <= 1'b1;
      @(posedge clk_sys);
      tx_start <= 1'b0;
      rd(5'h02, 8'h20);
      @(posedge clk_sys);
      tx_ok <= 1'b1;
      @(posedge clk_sys);
      tx_ok <= 1'b0;
      rd(5'h02, 8'h0c);
      rd(5'h03, 8'h02);
      wr(5'h01, 8'h01);
      wr(5'h01, 8'h02);
      rd(5'h02, 8'h04);
      rd(5'h03, 8'h02);
    end
  endtask
  task t_busoff;
    begin
      @(posedge clk_sys);
      bus_off_in <= 1'b1;
      ew <= 1'b1;
      @(posedge clk_sys);
      bus_off_in <= 1'b0;
      rd(5'h02, 8'hcc);
      chk({7'h0, hold}, 8'h01);
      rd(5'h04, 8'h5a);
      rd(5'h03, 8'h04);
      wr(5'h00, 8'h1e);
      repeat (128)
      begin
        @(posedge clk_sys);
        bus_free <= 1'b1;
        @(posedge clk_sys);
        bus_free <= 1'b0;
      end
      ew <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk({7'h0, seen}, 8'h01);
      rd(5'h02, 8'h0c);
      rd(5'h03, 8'h04);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // watchdog: whole run needs well under 2000 cycles
  initial
  begin
    #80000;
    error_cnt = error_cnt + 1;
    summarize;
  end
  initial
  begin
    {cpu_wr, cpu_rd, tx_start, tx_ok, bus_off_in} = 5'h00;
    {bus_free, resync_req, seen, ew} = 4'h0;
    cpu_addr = 5'h00;
    cpu_wdata = 8'h00;
    resync_phase = 4'h0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_timing;
    t_rx;
    t_tx;
    t_busoff;
    summarize;
  end
endmodule
bind csf_ctrl csf_ctrl_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .tx_ok(tx_ok),
  .tx_pending(tx_pending), .bus_off_in(bus_off_in),
  .err_cnt_reset(err_cnt_reset), .proto_hold(proto_hold),
  .tq_tick(tq_tick), .resync_req(resync_req), .resync_jump(resync_jump));
